//--- rtl/eisc_pin_sense.sv
// Edge and level detector for one external interrupt pin
`timescale 1ns/1ps
module eisc_pin_sense (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               pin,
  input  wire logic [1:0]         code,
  input  wire logic               invert,
  input  wire logic               rise_low,
  output logic                    edge_hit,
  output logic                    level_hit
);

  typedef struct packed {
    logic primed;
    logic prev;
  } eisc_pin_state_t;

  eisc_pin_state_t q;
  eisc_pin_state_t d;
  logic            now_s;
  logic            was_s;
  logic            rise;
  logic            fall;

  // ---------------------------------------------------------------------
  // Detection
  // ---------------------------------------------------------------------
  // Inverting both samples turns falling into rising and low into high
  assign now_s = pin ^ invert;
  assign was_s = q.prev ^ invert;
  // No edge on the first cycle: the pin history is unknown before reset
  assign rise  = q.primed & now_s & ~was_s;
  assign fall  = q.primed & ~now_s & was_s;

  always_comb begin
    d        = q;
    d.primed = 1'b1;
    d.prev   = pin;
    edge_hit  = 1'b0;
    level_hit = 1'b0;
    unique case (eisc_pkg::eisc_sense_t'(code))
      eisc_pkg::SENSE_EDGE_LEVEL: begin
        edge_hit  = rise_low ? rise : fall;
        level_hit = ~now_s;
      end
      eisc_pkg::SENSE_RISE: begin
        edge_hit = rise;
      end
      eisc_pkg::SENSE_FALL: begin
        edge_hit = fall;
      end
      eisc_pkg::SENSE_BOTH: begin
        edge_hit = rise | fall;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

//--- rtl/eisc_pkg.sv
// Shared constants and types for the external interrupt sense control block
package eisc_pkg;

  // ---------------------------------------------------------------------
  // Register map (byte addresses on the bus)
  // ---------------------------------------------------------------------
  localparam logic [31:0] ADDR_SENSE  = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_ENABLE = 32'h0000_0008;
  localparam logic [31:0] ADDR_CLEAR  = 32'h0000_000C;

  // ---------------------------------------------------------------------
  // Sense control fields and reset values
  // ---------------------------------------------------------------------
  localparam int         V2_MSB       = 7;
  localparam int         V2_LSB       = 6;
  localparam int         C_INV_BIT    = 5;
  localparam int         V1_MSB       = 4;
  localparam int         V1_LSB       = 3;
  localparam int         V0_MSB       = 2;
  localparam int         V0_LSB       = 1;
  localparam int         D_INV_BIT    = 0;
  localparam logic [7:0] SENSE_RESET  = 8'h00;
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [1:0] PRIO_LEVEL3  = 2'h3;

  // Status bits 2:0 follow the vector number, bit 3 flags a refused write
  localparam int STATUS_W    = 4;
  localparam int EVT_REFUSED = 3;

  // ---------------------------------------------------------------------
  // Pin map: C[3:2] at 1:0, B[7:0] at 9:2, A3/A5 at 11:10,
  // D[6:4] at 14:12, D[3:1] at 17:15
  // ---------------------------------------------------------------------
  localparam int          N_PINS        = 18;
  localparam logic [17:0] MASK_VEC_TWO  = 18'h003FF;
  localparam logic [17:0] MASK_VEC_ONE  = 18'h00C00;
  localparam logic [17:0] MASK_VEC_ZERO = 18'h3F000;
  localparam logic [17:0] MASK_INV_C    = 18'h00003;
  localparam logic [17:0] MASK_INV_D    = 18'h07000;
  localparam logic [17:0] MASK_RISE_LOW = 18'h003FC;

  typedef enum logic [1:0] {
    SENSE_EDGE_LEVEL,
    SENSE_RISE,
    SENSE_FALL,
    SENSE_BOTH
  } eisc_sense_t;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_SENSE,
    REG_STATUS,
    REG_ENABLE,
    REG_CLEAR
  } eisc_reg_t;

endpackage

//--- rtl/eisc_top.sv
// External interrupt sense control with AHB-Lite register access
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module eisc_top (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic [1:0]         port_c_pins,
  input  wire logic [7:0]         port_b_pins,
  input  wire logic [1:0]         port_a_pins,
  input  wire logic [2:0]         port_d_hi_pins,
  input  wire logic [2:0]         port_d_lo_pins,
  input  wire logic               cpu_priority_high_bit,
  input  wire logic               cpu_priority_low_bit,
  input  wire logic [2:0]         ext_irq_ack,
  output logic                    ext_irq_vector_zero,
  output logic                    ext_irq_vector_one,
  output logic                    ext_irq_vector_two,
  output logic                    irq
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                    sense;
    logic [eisc_pkg::STATUS_W-1:0] enable;
    logic [eisc_pkg::STATUS_W-1:0] status;
    logic [2:0]                    pending;
    logic                          alive;
    logic                          wr_phase;
    eisc_pkg::eisc_reg_t           wr_sel;
    logic [31:0]                   rdata;
  } eisc_state_t;

  eisc_state_t                   q;
  eisc_state_t                   d;
  logic                          prio3;
  logic [eisc_pkg::N_PINS-1:0]   all_pins;
  logic [eisc_pkg::N_PINS-1:0]   edge_hit;
  logic [eisc_pkg::N_PINS-1:0]   level_hit;
  logic [eisc_pkg::N_PINS-1:0]   pin_inv;
  logic [1:0]                    pin_code [eisc_pkg::N_PINS];
  logic [2:0]                    vec_hit;
  logic [2:0]                    clr_pend;
  logic [eisc_pkg::STATUS_W-1:0] status_clr;
  logic                          refused;
  eisc_pkg::eisc_reg_t           addr_sel;
  logic                          addr_take;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic eisc_pkg::eisc_reg_t reg_decode(input logic [31:0] addr);
    eisc_pkg::eisc_reg_t sel;
    sel = eisc_pkg::REG_NONE;
    if (addr == eisc_pkg::ADDR_SENSE) begin
      sel = eisc_pkg::REG_SENSE;
    end else if (addr == eisc_pkg::ADDR_STATUS) begin
      sel = eisc_pkg::REG_STATUS;
    end else if (addr == eisc_pkg::ADDR_ENABLE) begin
      sel = eisc_pkg::REG_ENABLE;
    end else if (addr == eisc_pkg::ADDR_CLEAR) begin
      sel = eisc_pkg::REG_CLEAR;
    end
    return sel;
  endfunction

  function automatic logic [2:0] vector_reduce(input logic [eisc_pkg::N_PINS-1:0] hits);
    return {|(hits & eisc_pkg::MASK_VEC_TWO),
            |(hits & eisc_pkg::MASK_VEC_ONE),
            |(hits & eisc_pkg::MASK_VEC_ZERO)};
  endfunction

  // Both priority bits must be one for a sense register change
  assign prio3 = {cpu_priority_high_bit, cpu_priority_low_bit} == eisc_pkg::PRIO_LEVEL3;

  // ---------------------------------------------------------------------
  // Pin sensing
  // ---------------------------------------------------------------------
  assign all_pins = {port_d_lo_pins, port_d_hi_pins, port_a_pins, port_b_pins, port_c_pins};

  for (genvar i = 0; i < eisc_pkg::N_PINS; i++) begin : g_pin
    // Field select per pin group; port B and D[3:1] never see an inversion bit
    assign pin_code[i] = eisc_pkg::MASK_VEC_TWO[i] ?
                           q.sense[eisc_pkg::V2_MSB:eisc_pkg::V2_LSB] :
                         eisc_pkg::MASK_VEC_ONE[i] ?
                           q.sense[eisc_pkg::V1_MSB:eisc_pkg::V1_LSB] :
                           q.sense[eisc_pkg::V0_MSB:eisc_pkg::V0_LSB];
    assign pin_inv[i] = (eisc_pkg::MASK_INV_C[i] & q.sense[eisc_pkg::C_INV_BIT]) |
                        (eisc_pkg::MASK_INV_D[i] & q.sense[eisc_pkg::D_INV_BIT]);

    eisc_pin_sense u_sense (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .pin       (all_pins[i]),
      .code      (pin_code[i]),
      .invert    (pin_inv[i]),
      .rise_low  (eisc_pkg::MASK_RISE_LOW[i]),
      .edge_hit  (edge_hit[i]),
      .level_hit (level_hit[i])
    );
  end

  // A held level keeps re-raising the pending flag after each acknowledge
  assign vec_hit = vector_reduce(edge_hit | level_hit);

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  assign addr_take = hsel & hready & htrans[1];
  assign addr_sel  = reg_decode(haddr);

  always_comb begin
    d          = q;
    d.alive    = 1'b1;
    clr_pend   = 3'h0;
    status_clr = '0;
    refused    = 1'b0;

    // Data phase of a write
    if (q.wr_phase) begin
      unique case (q.wr_sel)
        eisc_pkg::REG_SENSE: begin
          if (prio3) begin
            d.sense = hwdata[7:0];
            if (hwdata[7:0] != q.sense) begin
              clr_pend = 3'h7;
            end
          end else begin
            refused = 1'b1;
          end
        end
        eisc_pkg::REG_ENABLE: begin
          d.enable = hwdata[eisc_pkg::STATUS_W-1:0];
        end
        eisc_pkg::REG_CLEAR: begin
          status_clr = hwdata[eisc_pkg::STATUS_W-1:0];
        end
        eisc_pkg::REG_STATUS: begin
          d.enable = q.enable;
        end
        eisc_pkg::REG_NONE: begin
          d.enable = q.enable;
        end
      endcase
    end

    // New events win over a clear in the same cycle
    d.status  = (q.status & ~status_clr) | {refused, vec_hit};
    d.pending = (q.pending & ~(clr_pend | ext_irq_ack)) | vec_hit;

    // Address phase; reads are captured here so data stand in the data phase
    d.wr_phase = 1'b0;
    if (addr_take) begin
      d.wr_phase = hwrite;
      d.wr_sel   = addr_sel;
      if (!hwrite) begin
        unique case (addr_sel)
          eisc_pkg::REG_SENSE:  d.rdata = {24'h000000, q.sense};
          eisc_pkg::REG_STATUS: d.rdata = {28'h0000000, q.status};
          eisc_pkg::REG_ENABLE: d.rdata = {28'h0000000, q.enable};
          eisc_pkg::REG_CLEAR:  d.rdata = 32'h0000_0000;
          eisc_pkg::REG_NONE:   d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q         <= '0;
      q.sense   <= eisc_pkg::SENSE_RESET;
      q.enable  <= eisc_pkg::ENABLE_RESET;
      q.status  <= eisc_pkg::STATUS_RESET;
      q.wr_sel  <= eisc_pkg::REG_NONE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // Zero wait states; hsize is not checked since only words are mapped
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = q.rdata;
  assign ext_irq_vector_zero = q.pending[0];
  assign ext_irq_vector_one  = q.pending[1];
  assign ext_irq_vector_two  = q.pending[2];
  assign irq                 = |(q.status & q.enable);

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_sense_write;
    q.wr_phase && (q.wr_sel == eisc_pkg::REG_SENSE);
  endsequence

  sequence s_sense_write_ok;
    s_sense_write ##0 prio3;
  endsequence

  sequence s_sense_write_locked;
    s_sense_write ##0 !prio3;
  endsequence

  a_sense_write_taken: assert property (
    s_sense_write_ok |=> q.sense == $past(hwdata[7:0]))
    else $error("sense write at level 3 not stored");

  a_locked_write_kept: assert property (
    s_sense_write_locked |=> $stable(q.sense) && q.status[eisc_pkg::EVT_REFUSED])
    else $error("sense write below level 3 changed the register");

  a_reconfig_clears: assert property (
    s_sense_write_ok ##0 (hwdata[7:0] != q.sense) ##0 (vec_hit == 3'h0)
    |=> q.pending == 3'h0)
    else $error("changed sense write did not clear pending");

  a_c_level_mode: assert property (
    q.alive && q.sense[7:6] == 2'h0 && port_c_pins[0] == q.sense[5]
    |=> q.pending[2])
    else $error("port C level mode did not raise vector two");

  a_c_rise_only: assert property (
    q.alive && q.sense[7:6] == 2'h1 && !q.sense[5] && $rose(port_c_pins[0])
    |=> q.pending[2])
    else $error("port C rising edge missed");

  a_c_fall_inverted: assert property (
    q.alive && q.sense[7:6] == 2'h2 && q.sense[5] && $rose(port_c_pins[1])
    |=> q.pending[2])
    else $error("port C inverted falling mode missed a rising edge");

  a_c_both_edges: assert property (
    q.alive && q.sense[7:6] == 2'h3 && $fell(port_c_pins[1])
    |=> q.pending[2])
    else $error("port C both-edge mode missed a falling edge");

  a_b_low_level: assert property (
    q.alive && q.sense[7:6] == 2'h0 && !port_b_pins[3]
    |=> q.pending[2])
    else $error("port B low level did not raise vector two");

  a_a_fall_only: assert property (
    q.alive && q.sense[4:3] == 2'h2 && $fell(port_a_pins[1])
    |=> q.pending[1])
    else $error("port A falling edge missed");

  a_d_high_level: assert property (
    q.alive && q.sense[2:1] == 2'h0 && q.sense[0] && port_d_hi_pins[2]
    |=> q.pending[0])
    else $error("port D inverted level mode missed a high level");

  a_d_rise_inverted: assert property (
    q.alive && q.sense[2:1] == 2'h2 && q.sense[0] && $rose(port_d_hi_pins[0])
    |=> q.pending[0])
    else $error("port D inverted falling mode missed a rising edge");

  a_d_both_edges: assert property (
    q.alive && q.sense[2:1] == 2'h3 && $rose(port_d_hi_pins[1])
    |=> q.pending[0])
    else $error("port D both-edge mode missed a rising edge");

  a_dlo_rise_only: assert property (
    q.alive && q.sense[2:1] == 2'h1 && q.sense[0] && $rose(port_d_lo_pins[0])
    |=> q.pending[0])
    else $error("port D low pins wrongly inverted");

  a_irq_follows: assert property (
    s_sense_write_locked |=> ##1 (irq == q.enable[eisc_pkg::EVT_REFUSED]) || (|q.enable[2:0]))
    else $error("refused write did not reach the interrupt output");

  a_c_rise_inverted: assert property (
    q.alive && q.sense[7:6] == 2'h1 && q.sense[5] && $fell(port_c_pins[1])
    |=> q.pending[2])
    else $error("port C inverted rising mode missed a falling edge");

  a_c_fall_plain: assert property (
    q.alive && q.sense[7:6] == 2'h2 && !q.sense[5] && $fell(port_c_pins[0])
    |=> q.pending[2])
    else $error("port C falling edge missed");

  a_b_rise_edge: assert property (
    q.alive && q.sense[7:6] == 2'h0 && $rose(port_b_pins[0])
    |=> q.pending[2])
    else $error("port B rising edge missed");

  a_a_low_level: assert property (
    q.alive && q.sense[4:3] == 2'h0 && !port_a_pins[0]
    |=> q.pending[1])
    else $error("port A low level did not raise vector one");

  a_d_fall_plain: assert property (
    q.alive && q.sense[2:1] == 2'h2 && !q.sense[0] && $fell(port_d_hi_pins[2])
    |=> q.pending[0])
    else $error("port D falling edge missed");

  a_same_write_keeps: assert property (
    s_sense_write_ok ##0 (hwdata[7:0] == q.sense) ##0 (ext_irq_ack == 3'h0)
    |=> (q.pending & $past(q.pending)) == $past(q.pending))
    else $error("unchanged sense write cleared pending");

  a_vec_sets_pending: assert property (
    vec_hit != 3'h0
    |=> (q.pending & $past(vec_hit)) == $past(vec_hit))
    else $error("pin event lost to a pending clear");

  a_status_sets: assert property (
    vec_hit != 3'h0
    |=> (q.status[2:0] & $past(vec_hit)) == $past(vec_hit))
    else $error("pin event did not set its status bit");

  a_ack_clears: assert property (
    ext_irq_ack[1] && !vec_hit[1]
    |=> !q.pending[1])
    else $error("acknowledge did not clear vector one");

  a_status_clear: assert property (
    q.wr_phase && q.wr_sel == eisc_pkg::REG_CLEAR && hwdata[1] && !vec_hit[1]
    |=> !q.status[1])
    else $error("status clear left vector one set");

  a_sense_readback: assert property (
    addr_take && !hwrite && addr_sel == eisc_pkg::REG_SENSE
    |=> hrdata == {24'h000000, $past(q.sense)})
    else $error("sense read returned a wrong value");

endmodule

//--- testbench/eisc_pin_model.sv
// Pin-side model of the external interrupt sources
`timescale 1ns/1ps
module eisc_pin_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [17:0] want,
  output logic      [1:0]  c_pins,
  output logic      [7:0]  b_pins,
  output logic      [1:0]  a_pins,
  output logic      [2:0]  d_hi_pins,
  output logic      [2:0]  d_lo_pins
);
  logic [17:0] pins_q;

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  // Pins move just after an edge, so no edge is ever seen half-settled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_q <= 18'h3FFFF;
    end else begin
      pins_q <= want;
    end
  end

  assign c_pins    = pins_q[1:0];
  assign b_pins    = pins_q[9:2];
  assign a_pins    = pins_q[11:10];
  assign d_hi_pins = pins_q[14:12];
  assign d_lo_pins = pins_q[17:15];
endmodule

//--- testbench/testbench.sv
// Self-checking testbench for the interrupt sense control block
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [31:0] ex;
    logic [31:0] mk;
  } eisc_note_t;

  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  c_p, a_p;
  logic [7:0]  b_p;
  logic [2:0]  dh_p, dl_p, vecs;
  logic        cpu_hi = 1'b1;
  logic        cpu_lo = 1'b1;
  logic [2:0]  ack = 3'h0;
  logic        irq;
  logic [17:0] want = 18'h3FFFF;
  logic [17:0] sv, tg;
  logic [7:0]  s8;
  logic        rd_q = 1'b0;
  logic        e;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;
  eisc_note_t  notes[$];
  eisc_note_t  n;
  logic [17:0] gm [5] = '{eisc_pkg::MASK_INV_C, eisc_pkg::MASK_RISE_LOW, eisc_pkg::MASK_VEC_ONE,
                          eisc_pkg::MASK_INV_D, eisc_pkg::MASK_VEC_ZERO & ~eisc_pkg::MASK_INV_D};
  int          gv [5] = '{2, 2, 1, 0, 0};
  int          gl [5] = '{eisc_pkg::V2_LSB, eisc_pkg::V2_LSB, eisc_pkg::V1_LSB,
                          eisc_pkg::V0_LSB, eisc_pkg::V0_LSB};

  always #2.5 hclk = ~hclk;

  eisc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_c_pins(c_p),
    .port_b_pins(b_p), .port_a_pins(a_p), .port_d_hi_pins(dh_p), .port_d_lo_pins(dl_p),
    .cpu_priority_high_bit(cpu_hi), .cpu_priority_low_bit(cpu_lo), .ext_irq_ack(ack),
    .ext_irq_vector_zero(vecs[0]), .ext_irq_vector_one(vecs[1]),
    .ext_irq_vector_two(vecs[2]), .irq(irq));

  eisc_pin_model pins_u (.hclk(hclk), .hresetn(hresetn), .want(want), .c_pins(c_p),
    .b_pins(b_p), .a_pins(a_p), .d_hi_pins(dh_p), .d_lo_pins(dl_p));

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Read results are judged when the data phase ends
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up;
    end
    if (rd_q && hreadyout === 1'b1) begin
      n = notes.pop_front();
      check(hrdata & n.mk, n.ex & n.mk);
      check({31'h0, hresp}, 32'h0);
    end
  end

  // ---------------------------------------------------------------
  // Bus master
  // ---------------------------------------------------------------
  task automatic wait_rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    if (!w) notes.push_back(eisc_note_t'{ex: d, mk: m});
    wait_rdy;
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= w ? d : 32'h0;
    rd_q   <= !w;
    wait_rdy;
    rd_q   <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 32'h0);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
    bus(a, 1'b0, d, m);
  endtask

  // Direction: 0 falling, 1 rising, 2 steady low, 3 steady high
  function automatic logic hit(input int g, input int c, input logic inv, input int dir);
    logic ig, lv, r, f;
    ig = (g == 0 || g == 3) && inv;
    lv = (g == 1) ? 1'b0 : ig;
    r  = c == 3 || (c == 1 && !ig) || (c == 2 && ig);
    f  = c == 3 || (c == 1 && ig) || (c == 2 && !ig);
    if (dir < 2) hit = (c == 0) || (dir == 1 ? r : f);
    else hit = (c == 0) && (lv == dir[0]);
  endfunction

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(77798));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(eisc_pkg::ADDR_SENSE, {24'h0, eisc_pkg::SENSE_RESET}, 32'hFFFFFFFF);
    rd(eisc_pkg::ADDR_STATUS, {28'h0, eisc_pkg::STATUS_RESET}, 32'hFFFFFFFF);
    rd(eisc_pkg::ADDR_ENABLE, {28'h0, eisc_pkg::ENABLE_RESET}, 32'hFFFFFFFF);
    $display("test reset values done");
    for (int p = 0; p < 3; p++) begin
      {cpu_hi, cpu_lo} <= 2'(p);
      wr(eisc_pkg::ADDR_SENSE, $urandom);
      rd(eisc_pkg::ADDR_SENSE, 32'h0, 32'hFFFFFFFF);
      rd(eisc_pkg::ADDR_STATUS, 32'h8, 32'h8);
      wr(eisc_pkg::ADDR_CLEAR, 32'h8);
    end
    {cpu_hi, cpu_lo} <= 2'h3;
    s8 = 8'($urandom);
    wr(eisc_pkg::ADDR_SENSE, {24'h0, s8});
    rd(eisc_pkg::ADDR_SENSE, {24'h0, s8}, 32'hFFFFFFFF);
    rd(eisc_pkg::ADDR_STATUS, 32'h0, 32'h8);
    wr(32'h10, $urandom);
    rd(32'h10, 32'h0, 32'hFFFFFFFF);
    s8 = 8'($urandom);
    wr(eisc_pkg::ADDR_ENABLE, {24'h0, s8});
    rd(eisc_pkg::ADDR_ENABLE, {28'h0, s8[3:0]}, 32'hFFFFFFFF);
    $display("test protection and map done");
    for (int g = 0; g < 5; g++) begin
      for (int c = 0; c < 4; c++) begin
        for (int i = 0; i < 2; i++) begin
          for (int dir = 0; dir < 4; dir++) begin
            // Pins of an inverted group idle low, away from their active level
            sv = i ? ~(eisc_pkg::MASK_INV_C | eisc_pkg::MASK_INV_D) : 18'h3FFFF;
            sv = (dir == 0 || dir == 3) ? sv | gm[g] : sv & ~gm[g];
            want <= sv;
            s8 = (8'(c) << gl[g]) | (8'(i) << eisc_pkg::C_INV_BIT) | 8'(i);
            wr(eisc_pkg::ADDR_SENSE, {24'h0, s8});
            repeat (3) @(posedge hclk);
            ack <= 3'h7;
            wr(eisc_pkg::ADDR_CLEAR, 32'hF);
            ack <= 3'h0;
            tg = 18'($urandom) & gm[g];
            if (tg == 18'h0) tg = gm[g];
            if (dir < 2) want <= sv ^ tg;
            repeat (4) @(negedge hclk);
            e = hit(g, c, i[0], dir);
            check({31'h0, vecs[gv[g]]}, {31'h0, e});
            rd(eisc_pkg::ADDR_STATUS, 32'(e) << gv[g], 32'h1 << gv[g]);
          end
        end
      end
    end
    $display("test sense modes done");
    want <= ~eisc_pkg::MASK_VEC_ONE;
    wr(eisc_pkg::ADDR_SENSE, 32'h08);
    repeat (3) @(posedge hclk);
    ack <= 3'h7;
    wr(eisc_pkg::ADDR_CLEAR, 32'hF);
    ack <= 3'h0;
    wr(eisc_pkg::ADDR_ENABLE, 32'h0);
    want <= 18'h3FFFF;
    repeat (4) @(negedge hclk);
    check({31'h0, vecs[1]}, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(eisc_pkg::ADDR_SENSE, 32'h08);
    @(negedge hclk);
    check({31'h0, vecs[1]}, 32'h1);
    wr(eisc_pkg::ADDR_ENABLE, 32'h2);
    @(negedge hclk);
    check({31'h0, irq}, 32'h1);
    wr(eisc_pkg::ADDR_ENABLE, 32'h1);
    @(negedge hclk);
    check({31'h0, irq}, 32'h0);
    wr(eisc_pkg::ADDR_ENABLE, 32'h2);
    wr(eisc_pkg::ADDR_STATUS, 32'h0);
    rd(eisc_pkg::ADDR_STATUS, 32'h2, 32'hF);
    wr(eisc_pkg::ADDR_CLEAR, 32'h2);
    @(negedge hclk);
    check({31'h0, irq}, 32'h0);
    wr(eisc_pkg::ADDR_SENSE, 32'h09);
    @(negedge hclk);
    check({31'h0, vecs[1]}, 32'h0);
    $display("test pending clear and interrupt done");
    repeat (4) @(posedge hclk);
    wrap_up;
  end
endmodule
